// ===== design/tchac_pkg.sv
package tchac_pkg;
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned ACK_CRIT_US   = 140;
    localparam int unsigned ACK_CRIT_CYC  = ACK_CRIT_US * CLK_MHZ;
    localparam int unsigned ACK_STORE_US  = 100;
    localparam int unsigned ACK_STORE_CYC = ACK_STORE_US * CLK_MHZ;
    localparam int unsigned CNT_W         = 16;
    localparam int unsigned SMP_W         = 16;
    localparam int unsigned ACC_W         = 20;
    localparam int unsigned AVG_CNT_W     = 4;
    // Averaging depth select: 2, 4, 8 or 16 samples
    localparam logic [1:0]  AVG_SEL_2     = 2'h0;
    localparam logic [1:0]  AVG_SEL_4     = 2'h1;
    localparam logic [1:0]  AVG_SEL_8     = 2'h2;
    localparam logic [1:0]  AVG_SEL_16    = 2'h3;

    typedef enum logic [1:0] {
        TCHAC_IDLE      = 2'b00,
        TCHAC_CRIT      = 2'b01,
        TCHAC_STORE_ACK = 2'b10,
        TCHAC_STORE_BSY = 2'b11
    } tchac_state_e;
endpackage

// ===== design/tchac_avg.sv
`timescale 1ns/100ps
`default_nettype none
module tchac_avg
    import tchac_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [SMP_W-1:0] in_data,
    input  wire logic             avg_en,
    input  wire logic [1:0]       avg_sel,
    output logic                  out_valid,
    output logic [SMP_W-1:0]      out_data
);
    typedef struct packed {
        logic [AVG_CNT_W-1:0] cnt;
        logic [ACC_W-1:0]     acc;
        logic [1:0]           sel;
        logic                 vld;
        logic [SMP_W-1:0]     dat;
    } tchac_avg_s;

    tchac_avg_s q;
    tchac_avg_s d;
    logic [AVG_CNT_W-1:0] last;
    logic [ACC_W-1:0]     sum;

    always_comb begin
        case (q.sel)
            AVG_SEL_2:  last = 4'h1;
            AVG_SEL_4:  last = 4'h3;
            AVG_SEL_8:  last = 4'h7;
            default:    last = 4'hf;
        endcase
        sum = q.acc + {{(ACC_W-SMP_W){1'b0}}, in_data};
        d = q;
        d.vld = 1'b0;
        d.sel = avg_sel;
        if (!avg_en) begin
            d.cnt = '0;
            d.acc = '0;
            d.vld = in_valid;
            if (in_valid) begin
                d.dat = in_data;
            end
        end else if (avg_sel != q.sel) begin
            // Depth changed mid-window: restart rather than mix depths
            d.cnt = '0;
            d.acc = '0;
        end else if (in_valid) begin
            if (q.cnt == last) begin
                d.vld = 1'b1;
                d.cnt = '0;
                d.acc = '0;
                case (q.sel)
                    AVG_SEL_2:  d.dat = sum[SMP_W:1];
                    AVG_SEL_4:  d.dat = sum[SMP_W+1:2];
                    AVG_SEL_8:  d.dat = sum[SMP_W+2:3];
                    default:    d.dat = sum[SMP_W+3:4];
                endcase
            end else begin
                d.cnt = q.cnt + 4'h1;
                d.acc = sum;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign out_valid = q.vld;
    assign out_data  = q.dat;

    a_avg_window: assert property (@(posedge clk_sys) disable iff (rst)
        (avg_en && avg_sel == q.sel && in_valid && q.cnt == last) |=> (out_valid && q.cnt == 4'h0))
        else $error("averaged sample missing at window end");
    a_avg_nofire: assert property (@(posedge clk_sys) disable iff (rst)
        (avg_en && $past(avg_en) && out_valid) |-> $past(q.cnt == last && in_valid))
        else $error("averaged sample out before window filled");
endmodule
`default_nettype wire

// ===== design/tchac_top.sv
`timescale 1ns/100ps
`default_nettype none
module tchac_top
    import tchac_pkg::*;
#(
    parameter int unsigned CRIT_LIMIT  = ACK_CRIT_CYC,
    parameter int unsigned STORE_LIMIT = ACK_STORE_CYC
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             req_valid,
    input  wire logic             req_store,
    input  wire logic             svc_done,
    input  wire logic             nvm_done,
    input  wire logic             bus_active,
    input  wire logic             scan_start,
    input  wire logic             sample_valid,
    input  wire logic [SMP_W-1:0] sample_raw,
    input  wire logic             avg_en,
    input  wire logic [1:0]       avg_sel,
    input  wire logic             drop_en,
    output logic                  ack,
    output logic                  nack,
    output logic                  nvm_start,
    output logic                  store_busy,
    output logic                  dropped,
    output logic                  out_valid,
    output logic [SMP_W-1:0]      out_data
);
    localparam logic [CNT_W-1:0] CRIT_LAST = CNT_W'(CRIT_LIMIT - 1);

    typedef struct packed {
        tchac_state_e     st;
        logic [CNT_W-1:0] cnt;
        logic             ack;
        logic             nack;
        logic             nvm_start;
        logic             busy;
        logic             in_scan;
        logic             dirty;
        logic             dropped;
        logic             fvld;
        logic [SMP_W-1:0] fdat;
    } tchac_top_s;

    tchac_top_s q;
    tchac_top_s d;
    logic       hit;

    always_comb begin
        d = q;
        d.ack       = 1'b0;
        d.nack      = 1'b0;
        d.nvm_start = 1'b0;
        d.dropped   = 1'b0;
        d.fvld      = 1'b0;
        case (q.st)
            TCHAC_IDLE: begin
                d.cnt = '0;
                if (req_valid && req_store) begin
                    d.st        = TCHAC_STORE_ACK;
                    d.nvm_start = 1'b1;
                    d.busy      = 1'b1;
                end else if (req_valid) begin
                    d.st = TCHAC_CRIT;
                end
            end
            TCHAC_CRIT: begin
                d.nack = req_valid;
                d.cnt  = q.cnt + 16'h0001;
                // Service late: ack anyway so the host is never held past the bound
                if (svc_done || q.cnt == CRIT_LAST) begin
                    d.ack = 1'b1;
                    d.st  = TCHAC_IDLE;
                end
            end
            TCHAC_STORE_ACK: begin
                d.nack = req_valid;
                d.ack  = 1'b1;
                d.st   = TCHAC_STORE_BSY;
            end
            TCHAC_STORE_BSY: begin
                // Refusal holds even in the cycle the write completes
                d.nack = req_valid;
                if (nvm_done) begin
                    d.busy = 1'b0;
                    d.st   = TCHAC_IDLE;
                end
            end
            default: begin
                d.st   = TCHAC_IDLE;
                d.busy = 1'b0;
            end
        endcase

        // Bus traffic in the scan's first cycle counts as during the scan
        hit = q.dirty || bus_active;
        if (scan_start) begin
            d.in_scan = 1'b1;
            d.dirty   = bus_active;
        end else if (q.in_scan && bus_active) begin
            d.dirty = 1'b1;
        end
        if (sample_valid) begin
            d.in_scan = 1'b0;
            d.dirty   = 1'b0;
            if (drop_en && (q.in_scan || scan_start) && hit) begin
                d.dropped = 1'b1;
            end else begin
                d.fvld = 1'b1;
                d.fdat = sample_raw;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    tchac_avg u_avg (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (q.fvld),
        .in_data   (q.fdat),
        .avg_en    (avg_en),
        .avg_sel   (avg_sel),
        .out_valid (out_valid),
        .out_data  (out_data)
    );

    assign ack        = q.ack;
    assign nack       = q.nack;
    assign nvm_start  = q.nvm_start;
    assign store_busy = q.busy;
    assign dropped    = q.dropped;

    sequence s_store_taken;
        q.st == TCHAC_IDLE && req_valid && req_store;
    endsequence
    sequence s_store_acked;
        ##1 (nvm_start && store_busy) ##1 ack;
    endsequence

    a_crit_bound: assert property (@(posedge clk_sys) disable iff (rst)
        (q.st == TCHAC_CRIT) |-> (q.cnt < CNT_W'(CRIT_LIMIT)))
        else $error("critical ack counter past its bound");
    a_crit_force: assert property (@(posedge clk_sys) disable iff (rst)
        (q.st == TCHAC_CRIT && q.cnt == CRIT_LAST) |=> (ack && q.st == TCHAC_IDLE))
        else $error("critical ack not forced at bound");
    a_store_ack: assert property (@(posedge clk_sys) disable iff (rst)
        s_store_taken |-> s_store_acked)
        else $error("store command not acknowledged in time");
    a_store_fast: assert property (@(posedge clk_sys) disable iff (rst)
        (STORE_LIMIT >= 2) && $rose(store_busy) |-> ##1 ack)
        else $error("store ack later than its bound");
    a_busy_refuse: assert property (@(posedge clk_sys) disable iff (rst)
        (q.st == TCHAC_STORE_BSY && req_valid) |=> (nack && !ack && !nvm_start))
        else $error("access taken while store in progress");
    a_busy_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (store_busy && !nvm_done) |=> store_busy)
        else $error("busy ended before write completed");
    a_drop_sample: assert property (@(posedge clk_sys) disable iff (rst)
        (drop_en && sample_valid && q.in_scan && q.dirty) |=> (dropped && !q.fvld))
        else $error("disturbed sample was not discarded");

    // Critical access path, step by step
    sequence s_crit_taken;
        q.st == TCHAC_IDLE && req_valid && !req_store;
    endsequence
    sequence s_crit_entered;
        ##1 (q.st == TCHAC_CRIT && q.cnt == '0 && !ack && !nvm_start);
    endsequence
    sequence s_crit_served;
        q.st == TCHAC_CRIT && svc_done;
    endsequence
    sequence s_crit_waiting;
        q.st == TCHAC_CRIT && !svc_done && q.cnt != CRIT_LAST;
    endsequence

    a_crit_entry: assert property (@(posedge clk_sys) disable iff (rst)
        s_crit_taken |-> s_crit_entered)
        else $error("critical access not taken from idle");
    a_crit_served: assert property (@(posedge clk_sys) disable iff (rst)
        s_crit_served |=> (ack && q.st == TCHAC_IDLE))
        else $error("served access not acknowledged next cycle");
    a_crit_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        s_crit_waiting |=> (!ack && q.st == TCHAC_CRIT))
        else $error("critical access acknowledged before service or bound");

    // Store path: start pulse, ack, busy until the write completes
    sequence s_write_done;
        q.st == TCHAC_STORE_BSY && nvm_done;
    endsequence
    sequence s_nvm_cleared;
        ##1 (!store_busy && q.st == TCHAC_IDLE);
    endsequence

    a_store_once: assert property (@(posedge clk_sys) disable iff (rst)
        nvm_start |=> (!nvm_start && ack && store_busy))
        else $error("store start not followed by ack");
    a_store_start: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(store_busy) |-> nvm_start)
        else $error("busy raised without a store start");
    a_busy_level: assert property (@(posedge clk_sys) disable iff (rst)
        (q.st == TCHAC_STORE_ACK || q.st == TCHAC_STORE_BSY) |-> store_busy)
        else $error("store in progress without busy");
    a_busy_release: assert property (@(posedge clk_sys) disable iff (rst)
        s_write_done |-> s_nvm_cleared)
        else $error("busy not released after write completed");

    // Sample path: only a scan hit by bus traffic loses its sample
    a_drop_off: assert property (@(posedge clk_sys) disable iff (rst)
        (sample_valid && !drop_en) |=> (!dropped && q.fvld))
        else $error("sample lost with drop filter off");
    a_drop_clean: assert property (@(posedge clk_sys) disable iff (rst)
        (sample_valid && !q.in_scan && !scan_start) |=> !dropped)
        else $error("sample outside a scan was discarded");
    a_drop_late: assert property (@(posedge clk_sys) disable iff (rst)
        (drop_en && q.in_scan && sample_valid && bus_active) |=> dropped)
        else $error("sample hit in its last scan cycle was kept");
endmodule
`default_nettype wire

// ===== bench/tchac_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module tchac_host_model (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic go,
    input  wire logic store,
    input  wire logic force_req,
    input  wire logic store_busy,
    output logic      req_valid,
    output logic      req_store
);
    logic booted;
    // High while the host has the sleep interval at a slow rate (8 Hz or 1 Hz)
    logic sleep_slow;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            booted     <= 1'b0;
            sleep_slow <= 1'b0;
            req_valid  <= 1'b0;
            req_store  <= 1'b0;
        end else begin
            booted    <= 1'b1;
            // Slow interval while a save is wanted or running, final rate after
            sleep_slow <= store || store_busy;
            // Only a deliberate refusal test may hit a busy device
            req_valid <= go && booted && (!store_busy || force_req);
            // A save at a fast interval would fail, so it is never asked for
            req_store <= go && store && sleep_slow;
        end
    end
endmodule
`default_nettype wire

// ===== bench/touch_ctrl_host_access_constraints_bench.sv
`timescale 1ns/100ps
`default_nettype none
module touch_ctrl_host_access_constraints_bench
    import tchac_pkg::*;
;
    localparam int CRIT = 20;
    logic clk_sys, rst, go, store, force_req, svc_done, nvm_done, bus_active;
    logic scan_start, sample_valid, avg_en, drop_en, req_valid, req_store;
    logic ack, nack, nvm_start, store_busy, dropped, out_valid;
    logic [1:0]       avg_sel;
    logic [SMP_W-1:0] sample_raw;
    logic [SMP_W-1:0] out_data;
    int               n_errors;
    int               num_checks;

    tchac_host_model host (.clk_sys(clk_sys), .rst(rst), .go(go), .store(store),
        .force_req(force_req), .store_busy(store_busy), .req_valid(req_valid),
        .req_store(req_store));
    tchac_top #(.CRIT_LIMIT(CRIT), .STORE_LIMIT(4)) uut (.clk_sys(clk_sys), .rst(rst),
        .req_valid(req_valid), .req_store(req_store), .svc_done(svc_done),
        .nvm_done(nvm_done), .bus_active(bus_active), .scan_start(scan_start),
        .sample_valid(sample_valid), .sample_raw(sample_raw), .avg_en(avg_en),
        .avg_sel(avg_sel), .drop_en(drop_en), .ack(ack), .nack(nack),
        .nvm_start(nvm_start), .store_busy(store_busy), .dropped(dropped),
        .out_valid(out_valid), .out_data(out_data));

    task automatic end_of_test();
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic c, input string m);
        num_checks++;
        if (c !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // Returns on the edge where the device takes the request
    task automatic req(input logic s, input logic f);
        @(posedge clk_sys) go <= 1'b1;
        store <= s;
        force_req <= f;
        @(posedge clk_sys) go <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wait_ack(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 40);
    endtask
    task automatic wait_out(output logic got);
        got = 1'b0;
        repeat (6) begin
            @(posedge clk_sys);
            if (out_valid === 1'b1)
                got = 1'b1;
        end
    endtask
    task automatic crit_fast();
        int n;
        req(1'b0, 1'b0);
        svc_done <= 1'b1;
        @(posedge clk_sys) svc_done <= 1'b0;
        wait_ack(n);
        chk(n == 1, "served access not acked next cycle");
    endtask
    task automatic crit_slow();
        int n;
        req(1'b0, 1'b0);
        wait_ack(n);
        chk(ack === 1'b1 && n > 1 && n <= CRIT + 2, "forced ack outside bound");
    endtask
    task automatic store_seq();
        @(posedge clk_sys) store <= 1'b1;
        req(1'b1, 1'b0);
        @(posedge clk_sys) chk(nvm_start === 1'b1 && store_busy === 1'b1, "no store start");
        @(posedge clk_sys) chk(ack === 1'b1 && nvm_start === 1'b0, "store ack late");
        req(1'b0, 1'b1);
        @(posedge clk_sys) chk(nack === 1'b1 && ack === 1'b0, "busy access not refused");
        force_req <= 1'b0;
        nvm_done <= 1'b1;
        @(posedge clk_sys) nvm_done <= 1'b0;
        chk(store_busy === 1'b1, "busy dropped early");
        @(posedge clk_sys) chk(store_busy === 1'b0, "busy stuck");
        crit_fast();
    endtask
    task automatic avg_run(input logic [1:0] sel, input int nsm, input logic en);
        logic got;
        int   sum;
        @(posedge clk_sys) avg_en <= en;
        avg_sel <= sel;
        drop_en <= 1'b0;
        repeat (3) @(posedge clk_sys);
        sum = 0;
        for (int i = 0; i < nsm; i++) begin
            @(posedge clk_sys) sample_valid <= 1'b1;
            sample_raw <= SMP_W'(100 + i * 7);
            sum += 100 + i * 7;
        end
        @(posedge clk_sys) sample_valid <= 1'b0;
        wait_out(got);
        chk(got === 1'b1 && out_data === SMP_W'(sum >> $clog2(nsm)), "bad average");
    endtask
    task automatic drop_run(input logic en, input logic bus, input logic exp);
        logic got;
        @(posedge clk_sys) drop_en <= en;
        avg_en <= 1'b0;
        scan_start <= 1'b1;
        @(posedge clk_sys) scan_start <= 1'b0;
        bus_active <= bus;
        // Traffic stands through the sample cycle as well
        @(posedge clk_sys) sample_valid <= 1'b1;
        sample_raw <= 16'h00ab;
        @(posedge clk_sys) sample_valid <= 1'b0;
        bus_active <= 1'b0;
        @(posedge clk_sys) chk(dropped === exp, "drop decision wrong");
        wait_out(got);
        chk(got === !exp, "dropped sample passed or kept one lost");
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #50000;
        n_errors++;
        end_of_test();
    end
    initial begin
        {rst, go, store, force_req, svc_done, nvm_done, bus_active} = 7'h40;
        {scan_start, sample_valid, drop_en, avg_sel, sample_raw} = '0;
        avg_en = 1'b0;
        n_errors = 0;
        num_checks = 0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        crit_fast();
        crit_slow();
        store_seq();
        avg_run(AVG_SEL_2, 1, 1'b0);
        for (int k = 0; k < 4; k++)
            avg_run(2'(k), 2 << k, 1'b1);
        drop_run(1'b1, 1'b1, 1'b1);
        drop_run(1'b1, 1'b0, 1'b0);
        drop_run(1'b0, 1'b1, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
